// >>> rtl/temp_alarm_pkg.sv
// constants, register layout and types for the temperature alarm and event block
// assumes a single clock domain and a register port driven by the serial bus engine
package temp_alarm_pkg;

    // register indexes on the register port
    localparam logic [3:0] ADDR_CONFIG = 4'h1;
    localparam logic [3:0] ADDR_UPPER = 4'h2;
    localparam logic [3:0] ADDR_LOWER = 4'h3;
    localparam logic [3:0] ADDR_CRIT = 4'h4;
    localparam logic [3:0] ADDR_TEMP = 4'h5;

    // configuration field positions
    localparam int CFG_HYST_HI = 10;
    localparam int CFG_HYST_LO = 9;
    localparam int CFG_POWER_DOWN = 8;
    localparam int CFG_CRIT_LOCK = 7;
    localparam int CFG_WIN_LOCK = 6;
    localparam int CFG_EVENT_CLEAR = 5;
    localparam int CFG_ALERT_FLAG = 4;
    localparam int CFG_EVENT_ENABLE = 3;
    localparam int CFG_CRIT_ONLY = 2;
    localparam int CFG_POLARITY = 1;
    localparam int CFG_EVENT_MODE = 0;

    // temperature data status bit positions
    localparam int TEMP_CRIT_BIT = 15;
    localparam int TEMP_UPPER_BIT = 14;
    localparam int TEMP_LOWER_BIT = 13;

    // values after reset
    localparam logic [1:0] HYST_RESET = 2'h0;
    localparam logic EVENT_MODE_RESET = 1'b1;
    localparam logic [10:0] LIMIT_RESET = 11'h000;
    localparam logic [12:0] TEMP_RESET = 13'h0000;
    localparam logic [15:0] READ_RESET = 16'h0000;

    // hysteresis in steps of 0.25 degC on the compared field
    localparam logic [11:0] HYST_OFF_STEPS = 12'h000;
    localparam logic [11:0] HYST_1P5_STEPS = 12'h006;
    localparam logic [11:0] HYST_3P0_STEPS = 12'h00C;
    localparam logic [11:0] HYST_6P0_STEPS = 12'h018;

    // hysteresis selection codes
    typedef enum logic [1:0] {
        HYST_NONE = 2'b00,
        HYST_1P5 = 2'b01,
        HYST_3P0 = 2'b10,
        HYST_6P0 = 2'b11
    } hyst_sel_t;

    // resolution codes of the converter
    typedef enum logic [1:0] {
        RES_9BIT = 2'b00,
        RES_10BIT = 2'b01,
        RES_11BIT = 2'b10,
        RES_12BIT = 2'b11
    } resolution_t;

endpackage

// >>> rtl/alarm_compare_if.sv
// bundle between the event control and its window comparator
// assumes both ends sit on the same clock; the comparator is pure logic
`timescale 1ns/1ns
`default_nettype none
interface alarm_compare_if;
    import temp_alarm_pkg::*;
    logic [10:0] sampleField; // new sample, bits 12..2
    logic [10:0] upperLimitValue; // upper window limit
    logic [10:0] lowerLimitValue; // lower window limit
    logic [10:0] criticalLimit; // critical limit
    hyst_sel_t hystSel; // hysteresis selection
    logic [2:0] flagsNow; // {crit, upper, lower} held state
    logic [2:0] flagsNext; // state after this sample

    modport control (
        output sampleField, upperLimitValue, lowerLimitValue, criticalLimit,
        output hystSel, flagsNow,
        input flagsNext
    );
    modport compare (
        input sampleField, upperLimitValue, lowerLimitValue, criticalLimit,
        input hystSel, flagsNow,
        output flagsNext
    );
endinterface
`default_nettype wire

// >>> rtl/alarm_window_compare.sv
// window comparator with hysteresis for the three alarm flags
// assumes two's complement fields of 0.25 degC steps; purely combinational
`timescale 1ns/1ns
`default_nettype none
module alarm_window_compare
    import temp_alarm_pkg::*;
(
    alarm_compare_if.compare cmp
);
    logic [11:0] hystSteps; // decoded hysteresis amount
    logic signed [11:0] sampleExt; // widened to keep limit minus hysteresis in range
    logic signed [11:0] upperExt;
    logic signed [11:0] lowerExt;
    logic signed [11:0] critExt;
    logic signed [11:0] upperLow; // upper limit minus hysteresis
    logic signed [11:0] lowerLow; // lower limit minus hysteresis
    logic signed [11:0] critLow; // critical limit minus hysteresis
    logic critNext;
    logic upperNext;
    logic lowerNext;

    // hysteresis decode, one setting shared by every limit
    always_comb begin
        case (cmp.hystSel)
            HYST_NONE: hystSteps = HYST_OFF_STEPS;
            HYST_1P5: hystSteps = HYST_1P5_STEPS;
            HYST_3P0: hystSteps = HYST_3P0_STEPS;
            HYST_6P0: hystSteps = HYST_6P0_STEPS;
            default: hystSteps = HYST_OFF_STEPS;
        endcase
    end

    // only bits 12..2 take part, whatever the resolution
    assign sampleExt = {cmp.sampleField[10], cmp.sampleField};
    assign upperExt = {cmp.upperLimitValue[10], cmp.upperLimitValue};
    assign lowerExt = {cmp.lowerLimitValue[10], cmp.lowerLimitValue};
    assign critExt = {cmp.criticalLimit[10], cmp.criticalLimit};
    assign upperLow = upperExt - $signed(hystSteps);
    assign lowerLow = lowerExt - $signed(hystSteps);
    assign critLow = critExt - $signed(hystSteps);

    // above: set over the limit, clear at or below limit minus hysteresis
    assign upperNext = (sampleExt > upperExt) ? 1'b1 :
        ((sampleExt <= upperLow) ? 1'b0 : cmp.flagsNow[1]);
    // below: set under limit minus hysteresis, clear back at the limit
    assign lowerNext = (sampleExt < lowerLow) ? 1'b1 :
        ((sampleExt >= lowerExt) ? 1'b0 : cmp.flagsNow[0]);
    // critical holds until at or below limit minus hysteresis
    assign critNext = (sampleExt > critExt) ? 1'b1 :
        ((sampleExt <= critLow) ? 1'b0 : cmp.flagsNow[2]);
    assign cmp.flagsNext = {critNext, upperNext, lowerNext};
endmodule
`default_nettype wire

// >>> rtl/temp_alarm_event_control.sv
// configuration, limit registers and event pin control of the temperature alarm
// assumes the register port and sample strobe come from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module temp_alarm_event_control
    import temp_alarm_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic clockEnable,
    input wire logic [3:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regWriteData,
    output logic [15:0] regReadData,
    input wire logic sampleValid,
    input wire logic [12:0] sampleTemp,
    input wire logic [1:0] resolutionCode,
    output logic powerDownOut,
    output logic eventPinOut,
    output logic eventPinOen
);
    alarm_compare_if cmpBus ();

    // configuration state
    hyst_sel_t hyst_q, hyst_d;
    logic powerDownBit_q, powerDownBit_d;
    logic criticalLimitLock_q, criticalLimitLock_d;
    logic windowLock_q, windowLock_d;
    logic eventEnable_q, eventEnable_d;
    logic criticalAlarmOnly_q, criticalAlarmOnly_d;
    logic alertPolarity_q, alertPolarity_d;
    logic eventMode_q, eventMode_d; // 1 = interrupt mode
    // limits, bits 12..2 only
    logic [10:0] upperLimit_q, upperLimit_d;
    logic [10:0] lowerLimit_q, lowerLimit_d;
    logic [10:0] critLimit_q, critLimit_d;
    // measured data and alarm state
    logic [12:0] tempData_q, tempData_d;
    logic [2:0] flags_q, flags_d; // {crit, upper, lower}
    logic intLatch_q, intLatch_d; // interrupt-mode event memory
    logic eventAsserted_q, eventAsserted_d;
    logic [15:0] readData_q, readData_d;
    logic pinOen_q, pinOen_d;

    // decode
    logic cfgWrite;
    logic anyLock;
    logic evaluate;
    logic clearRequest;
    logic newAlarm;
    logic condNext;
    logic [12:0] resMask;
    logic [12:0] sampleMasked;
    logic [15:0] configView;
    logic [15:0] tempView;

    assign cfgWrite = regWrite && (regAddr == ADDR_CONFIG);
    assign anyLock = criticalLimitLock_q || windowLock_q;
    assign evaluate = sampleValid && !powerDownBit_q;
    assign clearRequest = cfgWrite && regWriteData[CFG_EVENT_CLEAR] && eventMode_q;

    // unused fine bits read as zero at lower resolutions
    assign resMask = (resolutionCode == RES_9BIT) ? 13'h1FF8 :
        (resolutionCode == RES_10BIT) ? 13'h1FFC :
        (resolutionCode == RES_11BIT) ? 13'h1FFE : 13'h1FFF;
    assign sampleMasked = sampleTemp & resMask;

    // sticky lock bits; only a power-on reset clears them
    assign criticalLimitLock_d = criticalLimitLock_q ||
        (cfgWrite && regWriteData[CFG_CRIT_LOCK]);
    assign windowLock_d = windowLock_q || (cfgWrite && regWriteData[CFG_WIN_LOCK]);
    // power down may always be cleared, set only while unlocked
    assign powerDownBit_d = !cfgWrite ? powerDownBit_q :
        (!regWriteData[CFG_POWER_DOWN] ? 1'b0 : (anyLock ? powerDownBit_q : 1'b1));
    assign hyst_d = (cfgWrite && !anyLock) ?
        hyst_sel_t'(regWriteData[CFG_HYST_HI:CFG_HYST_LO]) : hyst_q;
    assign eventEnable_d = (cfgWrite && !anyLock) ?
        regWriteData[CFG_EVENT_ENABLE] : eventEnable_q;
    assign criticalAlarmOnly_d = (cfgWrite && !windowLock_q) ?
        regWriteData[CFG_CRIT_ONLY] : criticalAlarmOnly_q;
    assign alertPolarity_d = cfgWrite ? regWriteData[CFG_POLARITY] : alertPolarity_q;
    assign eventMode_d = cfgWrite ? regWriteData[CFG_EVENT_MODE] : eventMode_q;

    // limit writes keep bits 12..2; locked registers ignore writes
    assign upperLimit_d = (regWrite && regAddr == ADDR_UPPER && !windowLock_q) ?
        regWriteData[12:2] : upperLimit_q;
    assign lowerLimit_d = (regWrite && regAddr == ADDR_LOWER && !windowLock_q) ?
        regWriteData[12:2] : lowerLimit_q;
    assign critLimit_d = (regWrite && regAddr == ADDR_CRIT && !criticalLimitLock_q) ?
        regWriteData[12:2] : critLimit_q;

    // comparator sees the fresh sample, not the stored one
    assign cmpBus.sampleField = sampleMasked[12:2];
    assign cmpBus.upperLimitValue = upperLimit_q;
    assign cmpBus.lowerLimitValue = lowerLimit_q;
    assign cmpBus.criticalLimit = critLimit_q;
    assign cmpBus.hystSel = hyst_q;
    assign cmpBus.flagsNow = flags_q;

    alarm_window_compare u_compare (
        .cmp(cmpBus)
    );

    assign tempData_d = evaluate ? sampleMasked : tempData_q;
    assign flags_d = evaluate ? cmpBus.flagsNext : flags_q;

    // a fresh transition into an alarm that the source selection allows
    // only interrupt mode latches, so comparator mode leaves no stale latch behind
    assign newAlarm = evaluate && eventMode_q && ((cmpBus.flagsNext[2] && !flags_q[2]) ||
        (!criticalAlarmOnly_q && ((cmpBus.flagsNext[1] && !flags_q[1]) ||
        (cmpBus.flagsNext[0] && !flags_q[0]))));
    assign condNext = flags_d[2] || (!criticalAlarmOnly_d && (flags_d[1] || flags_d[0]));

    // a new alarm in the same cycle as a clear wins over the clear
    assign intLatch_d = newAlarm ? 1'b1 : (clearRequest ? 1'b0 : intLatch_q);
    assign eventAsserted_d = eventEnable_d && (eventMode_d ? intLatch_d : condNext);

    // open drain: drive low only when the pin level must be 0
    assign pinOen_d = !(eventAsserted_d ^ alertPolarity_d);

    // read views; clear bit always reads 0, reserved bits read 0
    assign configView = {5'h00, hyst_q, powerDownBit_q, criticalLimitLock_q, windowLock_q,
        1'b0, eventAsserted_q, eventEnable_q, criticalAlarmOnly_q, alertPolarity_q,
        eventMode_q};
    assign tempView = {flags_q, tempData_q};
    assign readData_d = !regRead ? readData_q :
        (regAddr == ADDR_CONFIG) ? configView :
        (regAddr == ADDR_UPPER) ? {3'h0, upperLimit_q, 2'h0} :
        (regAddr == ADDR_LOWER) ? {3'h0, lowerLimit_q, 2'h0} :
        (regAddr == ADDR_CRIT) ? {3'h0, critLimit_q, 2'h0} :
        (regAddr == ADDR_TEMP) ? tempView : READ_RESET;

    // configuration flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hyst_q <= HYST_NONE;
            powerDownBit_q <= 1'b0;
            criticalLimitLock_q <= 1'b0;
            windowLock_q <= 1'b0;
            eventEnable_q <= 1'b0;
            criticalAlarmOnly_q <= 1'b0;
            alertPolarity_q <= 1'b0;
            eventMode_q <= EVENT_MODE_RESET;
        end else if (clockEnable) begin
            hyst_q <= hyst_d;
            powerDownBit_q <= powerDownBit_d;
            criticalLimitLock_q <= criticalLimitLock_d;
            windowLock_q <= windowLock_d;
            eventEnable_q <= eventEnable_d;
            criticalAlarmOnly_q <= criticalAlarmOnly_d;
            alertPolarity_q <= alertPolarity_d;
            eventMode_q <= eventMode_d;
        end
    end

    // limit and sample flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            upperLimit_q <= LIMIT_RESET;
            lowerLimit_q <= LIMIT_RESET;
            critLimit_q <= LIMIT_RESET;
            tempData_q <= TEMP_RESET;
        end else if (clockEnable) begin
            upperLimit_q <= upperLimit_d;
            lowerLimit_q <= lowerLimit_d;
            critLimit_q <= critLimit_d;
            tempData_q <= tempData_d;
        end
    end

    // event state and output flops; pin released after reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            flags_q <= 3'h0;
            intLatch_q <= 1'b0;
            eventAsserted_q <= 1'b0;
            pinOen_q <= 1'b1;
            readData_q <= READ_RESET;
        end else if (clockEnable) begin
            flags_q <= flags_d;
            intLatch_q <= intLatch_d;
            eventAsserted_q <= eventAsserted_d;
            pinOen_q <= pinOen_d;
            readData_q <= readData_d;
        end
    end

    assign regReadData = readData_q;
    assign powerDownOut = powerDownBit_q;
    assign eventPinOut = 1'b0; // open drain only ever pulls low
    assign eventPinOen = pinOen_q;

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn || !clockEnable);

    sequence lockedPowerDownSet;
        anyLock && !powerDownBit_q && cfgWrite && regWriteData[CFG_POWER_DOWN];
    endsequence
    sequence configReadIssued;
        regRead && regAddr == ADDR_CONFIG;
    endsequence

    a_crit_lock_sticky: assert property (criticalLimitLock_q |=> criticalLimitLock_q)
        else $error("critical lock dropped");
    a_crit_limit_held: assert property (criticalLimitLock_q && regWrite &&
        regAddr == ADDR_CRIT |=> critLimit_q == $past(critLimit_q))
        else $error("critical limit changed while locked");
    a_window_limit_held: assert property (windowLock_q && regWrite &&
        (regAddr == ADDR_UPPER || regAddr == ADDR_LOWER) |=>
        upperLimit_q == $past(upperLimit_q) && lowerLimit_q == $past(lowerLimit_q))
        else $error("window limit changed while locked");
    a_power_down_refused: assert property (lockedPowerDownSet |=> !powerDownBit_q)
        else $error("power down set while locked");
    a_power_down_clear: assert property (cfgWrite && !regWriteData[CFG_POWER_DOWN]
        |=> !powerDownBit_q)
        else $error("power down clear refused");
    a_shutdown_frozen: assert property (powerDownBit_q && sampleValid |=>
        tempData_q == $past(tempData_q) && flags_q == $past(flags_q))
        else $error("state updated in shutdown");
    a_enable_gates_pin: assert property (!eventEnable_q |-> !eventAsserted_q)
        else $error("event asserted while disabled");
    a_pin_polarity: assert property (eventPinOen == !(eventAsserted_q ^ alertPolarity_q))
        else $error("pin level disagrees with polarity");
    a_clear_reads_zero: assert property (configReadIssued |=>
        regReadData[CFG_EVENT_CLEAR] == 1'b0 &&
        regReadData[CFG_ALERT_FLAG] == $past(eventAsserted_q))
        else $error("config read back wrong");
    a_comparator_follows: assert property (!eventMode_q && eventEnable_q &&
        !cfgWrite |=> eventAsserted_q == (flags_q[2] ||
        (!criticalAlarmOnly_q && (flags_q[1] || flags_q[0]))))
        else $error("comparator mode not following alarm");
    a_int_latch_holds: assert property (eventMode_q && eventAsserted_q && !cfgWrite
        |=> eventAsserted_q)
        else $error("interrupt event released without clear");
endmodule
`default_nettype wire

// >>> verification/event_line_pullup.sv
// system side of the open-drain event line: pull-up plus interrupt input
// assumes the device only ever pulls the line low while its enable is low
`timescale 1ns/1ns
`default_nettype none
module event_line_pullup (
    input wire logic eventPinOut,
    input wire logic eventPinOen,
    output logic pinLevel
);
    // released line floats up to the pull-up level, never holds the last value
    assign pinLevel = (eventPinOen == 1'b0) ? eventPinOut : 1'b1;
endmodule
`default_nettype wire

// >>> verification/tb_temp_alarm_event_control.sv
// self-checking bench for the alarm and event control, with a reference model
// assumes register and sample strobes are sampled on rising edges of one clock
`timescale 1ns/1ns
`default_nettype none
module tb_temp_alarm_event_control
    import temp_alarm_pkg::*;
;
    logic clock, rstn, clockEnable, regWrite, regRead, sampleValid;
    logic [3:0] regAddr; // register index
    logic [15:0] regWriteData, regReadData;
    logic [12:0] sampleTemp; // raw sample
    logic [1:0] resolutionCode;
    logic powerDownOut, eventPinOut, eventPinOen, pinLevel;
    int errors = 0;
    int testsRun = 0;
    int seed = 56; // fixed seed keeps runs repeatable
    int hs[4] = '{0, 6, 12, 24}; // hysteresis in quarter degrees
    // reference model state
    bit [1:0] hy;
    bit pd, cl, wl, en, co, pol, md, evt, fc, fu, fl;
    logic [10:0] up, lo, cr; // limits, bits 12..2
    logic [12:0] tq; // stored sample

    temp_alarm_event_control dut (
        .clock(clock), .rstn(rstn), .clockEnable(clockEnable), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWriteData(regWriteData),
        .regReadData(regReadData), .sampleValid(sampleValid), .sampleTemp(sampleTemp),
        .resolutionCode(resolutionCode), .powerDownOut(powerDownOut),
        .eventPinOut(eventPinOut), .eventPinOen(eventPinOen)
    );
    event_line_pullup sys (
        .eventPinOut(eventPinOut), .eventPinOen(eventPinOen), .pinLevel(pinLevel)
    );

    // free-running 50 ns clock
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // model back to its power-on state
    task automatic mreset;
        {hy, pd, cl, wl, en, co, pol, evt, fc, fu, fl, up, lo, cr, tq} = '0;
        md = 1'b1;
    endtask

    // sources that may raise the event: critical always, window unless masked
    function automatic logic [2:0] sv();
        return {fc, co ? 2'b00 : {fu, fl}};
    endfunction

    // event asserted state before the pin polarity is applied
    function automatic logic asr();
        return en & (md ? evt : |sv());
    endfunction

    function automatic logic [15:0] rexp(input logic [3:0] a);
        case (a)
            ADDR_CONFIG: return {5'h00, hy, pd, cl, wl, 1'b0, asr(), en, co, pol, md};
            ADDR_UPPER: return {3'h0, up, 2'h0};
            ADDR_LOWER: return {3'h0, lo, 2'h0};
            ADDR_CRIT: return {3'h0, cr, 2'h0};
            ADDR_TEMP: return {fc, fu, fl, tq};
            default: return 16'h0000; // unmapped index reads zero
        endcase
    endfunction

    task automatic cmp(input logic [15:0] g, input logic [15:0] e);
        testsRun++;
        if (g !== e) begin
            errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    // pin and power-down outputs against the model
    task automatic pins;
        logic e;
        e = asr() ? pol : ~pol;
        cmp({15'h0000, eventPinOen}, {15'h0000, e});
        cmp({15'h0000, pinLevel}, {15'h0000, e});
        cmp({15'h0000, powerDownOut}, {15'h0000, pd});
    endtask

    // config write in the model; locks judged on their old values
    task automatic cfgw(input logic [15:0] d);
        bit lk;
        lk = cl | wl;
        hy = lk ? hy : d[10:9];
        en = lk ? en : d[3];
        pd = !d[8] ? 1'b0 : (lk ? pd : 1'b1);
        co = wl ? co : d[2];
        cl = cl | d[7];
        wl = wl | d[6];
        pol = d[1];
        evt = (d[5] && md) ? 1'b0 : evt;
        md = d[0];
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] dIn);
        logic [15:0] d;
        d = dIn;
        if (a >= ADDR_UPPER && a <= ADDR_CRIT) begin
            d = d & 16'h1FFC;
            if (resolutionCode == 2'h0) begin
                d[2] = 1'b0;
            end
        end
        regAddr = a;
        regWriteData = d;
        regWrite = 1'b1;
        @(negedge clock);
        regWrite = 1'b0;
        @(negedge clock);
        // a write while the clock is gated must leave no trace
        if (clockEnable) begin
            case (a)
                ADDR_CONFIG: cfgw(d);
                ADDR_UPPER: up = wl ? up : d[12:2];
                ADDR_LOWER: lo = wl ? lo : d[12:2];
                ADDR_CRIT: cr = cl ? cr : d[12:2];
                default: ;
            endcase
        end
        pins();
    endtask

    task automatic rd(input logic [3:0] a);
        logic [15:0] e;
        e = rexp(a);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clock);
        regRead = 1'b0;
        @(negedge clock);
        cmp(regReadData, e);
    endtask

    // one conversion result; model evaluates flags and latch
    task automatic smp(input logic [12:0] t);
        int v, h;
        logic [2:0] old;
        sampleTemp = t;
        sampleValid = 1'b1;
        @(negedge clock);
        sampleValid = 1'b0;
        @(negedge clock);
        if (!pd) begin
            tq = t & (13'h1FFF << (3 - resolutionCode));
            v = int'($signed(tq[12:2]));
            h = hs[hy];
            old = sv();
            fc = fc ? (v > int'($signed(cr)) - h) : (v > int'($signed(cr)));
            fu = fu ? (v > int'($signed(up)) - h) : (v > int'($signed(up)));
            fl = fl ? (v < int'($signed(lo))) : (v < int'($signed(lo)) - h);
            evt = evt | (md & |(sv() & ~old));
        end
        pins();
    endtask

    task automatic test_done;
        if (errors == 0 && testsRun > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        test_done();
    end

    initial begin
        int h, i, q;
        int bs[11];
        int kc[11];
        bs = '{81, 81, 80, 41, 40, 41, 39, 40, 121, 121, 120};
        kc = '{0, -1, -1, 0, -1, -1, 0, 0, 0, -1, -1};
        {rstn, regWrite, regRead, sampleValid, regAddr, regWriteData, sampleTemp} = '0;
        clockEnable = 1'b1;
        resolutionCode = 2'h1;
        mreset();
        repeat (5) @(negedge clock);
        rstn = 1'b1;
        // reset values and two unmapped indexes
        for (i = 0; i < 7; i++) begin
            rd(4'(i));
        end
        // random limits read back with unused bits zero
        for (i = 0; i < 3; i++) begin
            q = $random(seed) % 256;
            wr(4'(2 + i), 16'(q * 4));
            rd(4'(2 + i));
        end
        wr(ADDR_UPPER, 16'h0140);
        wr(ADDR_LOWER, 16'h00A0);
        wr(ADDR_CRIT, 16'h01E0);
        // interrupt mode: latch, clear, no relatch while still high
        wr(ADDR_CONFIG, 16'h0009);
        smp(13'(81 << 2));
        rd(ADDR_CONFIG);
        smp(13'(82 << 2));
        wr(ADDR_CONFIG, 16'h0029);
        rd(ADDR_CONFIG);
        smp(13'(83 << 2));
        smp(13'(79 << 2));
        smp(13'(200 << 2));
        rd(ADDR_TEMP);
        // comparator mode over every hysteresis code, source mask and polarity
        for (h = 0; h < 4; h++) begin
            wr(ADDR_CONFIG, 16'((h << 9) | 8 | ((h & 1) << 2) | (h & 2) | ((h == 2) << 5)));
            for (i = 0; i < 11; i++) begin
                resolutionCode = 2'($random(seed));
                smp(13'(((bs[i] + kc[i] * hs[h]) << 2) | ($random(seed) & 3)));
                rd(ADDR_TEMP);
            end
        end
        // gated clock drops a write
        clockEnable = 1'b0;
        wr(ADDR_UPPER, 16'h0200);
        clockEnable = 1'b1;
        rd(ADDR_UPPER);
        // power down ignores samples
        wr(ADDR_CONFIG, 16'h0008);
        wr(ADDR_CONFIG, 16'h0108);
        smp(13'(200 << 2));
        rd(ADDR_TEMP);
        // locks: limits frozen, fields refused, power down clear still works
        wr(ADDR_CONFIG, 16'h01C8);
        wr(ADDR_UPPER, 16'h0400);
        wr(ADDR_CRIT, 16'h0400);
        wr(ADDR_CONFIG, 16'h0704);
        rd(ADDR_CONFIG);
        wr(ADDR_CONFIG, 16'h0000);
        wr(ADDR_CONFIG, 16'h0100);
        rd(ADDR_CONFIG);
        rd(ADDR_UPPER);
        rd(ADDR_CRIT);
        // second reset releases the locks
        rstn = 1'b0;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        mreset();
        pins();
        rd(ADDR_CONFIG);
        test_done();
    end
endmodule
`default_nettype wire
